/* File: design/cpq_pkg.sv */
// Constants and types shared by the cache parameter query responder.
package cpq_pkg;

    // Query leaf values.
    localparam logic [31:0] CPQ_LEAF_CACHE_PARAMS = 32'h0000_0004;
    localparam logic [31:0] CPQ_LEAF_BASIC_LAST = 32'h0000_0003;
    localparam logic [31:0] CPQ_LEAF_EXT_BASE = 32'h8000_0000;

    // Miscellaneous feature enables: reset value and the legacy leaf-limit bit.
    localparam logic [31:0] CPQ_MISC_RESET = 32'h0000_0000;
    localparam int CPQ_LEGACY_LIMIT_BIT = 22;

    // Cache type codes.
    localparam logic [4:0] CPQ_TYPE_NULL = 5'h00;
    localparam logic [4:0] CPQ_TYPE_DATA = 5'h01;
    localparam logic [4:0] CPQ_TYPE_INSTR = 5'h02;
    localparam logic [4:0] CPQ_TYPE_UNIFIED = 5'h03;

    // Field positions and widths in the first result word.
    localparam int CPQ_A_TYPE_LSB = 0;
    localparam int CPQ_A_TYPE_W = 5;
    localparam int CPQ_A_LEVEL_LSB = 5;
    localparam int CPQ_A_LEVEL_W = 3;
    localparam int CPQ_A_SELFINIT_BIT = 8;
    localparam int CPQ_A_FULLASSOC_BIT = 9;
    localparam int CPQ_A_RSVD_LSB = 10;
    localparam int CPQ_A_RSVD_W = 4;
    localparam int CPQ_A_SHARING_LSB = 14;
    localparam int CPQ_A_SHARING_W = 12;
    localparam int CPQ_A_CORES_LSB = 26;
    localparam int CPQ_A_CORES_W = 6;

    // Field positions and widths in the second result word.
    localparam int CPQ_B_LINE_LSB = 0;
    localparam int CPQ_B_LINE_W = 12;
    localparam int CPQ_B_PART_LSB = 12;
    localparam int CPQ_B_PART_W = 10;
    localparam int CPQ_B_WAYS_LSB = 22;
    localparam int CPQ_B_WAYS_W = 10;

    // Number of described cache levels; sub-indices at or above it report the null type.
    localparam int CPQ_NUM_LEVELS = 3;
    localparam int CPQ_IDX_W = 32;

    // One cache level description, counts in minus-one form.
    typedef struct packed {
        logic [4:0] cacheType;
        logic [2:0] level;
        logic selfInit;
        logic fullyAssoc;
        logic [11:0] sharingMinus1;
        logic [5:0] coresMinus1;
        logic [11:0] lineMinus1;
        logic [9:0] partMinus1;
        logic [9:0] waysMinus1;
        logic [31:0] setsMinus1;
    } cpq_level_type;

    typedef cpq_level_type cpq_table_type [CPQ_NUM_LEVELS];

    // Plain default hierarchy: 32 KB L1 data, 32 KB L1 instruction, 2 MB L2 unified.
    localparam cpq_table_type CPQ_TABLE = '{
        '{CPQ_TYPE_DATA, 3'h1, 1'b1, 1'b0, 12'h000, 6'h01, 12'h03f, 10'h000, 10'h007, 32'h0000_003f},
        '{CPQ_TYPE_INSTR, 3'h1, 1'b1, 1'b0, 12'h000, 6'h01, 12'h03f, 10'h000, 10'h007, 32'h0000_003f},
        '{CPQ_TYPE_UNIFIED, 3'h2, 1'b1, 1'b0, 12'h001, 6'h01, 12'h03f, 10'h000, 10'h007, 32'h0000_0fff}
    };

endpackage

/* File: design/cpq_table_if.sv */
// Carrier between the query responder and its cache level table.
`timescale 1ns/1ns
interface cpq_table_if;
    logic [31:0] subIndex;
    logic present;
    cpq_pkg::cpq_level_type entry;

    modport requester (output subIndex, input present, input entry);
    modport table_side (input subIndex, output present, output entry);
endinterface

/* File: design/cpq_level_table.sv */
// Lookup of one cache level description by zero-based sub-index.
`timescale 1ns/1ns
module cpq_level_table (
    cpq_table_if.table_side tbl
);

    logic [cpq_pkg::CPQ_NUM_LEVELS-1:0] hit;

    // One comparator per described level; sub-indices count up from zero.
    genvar i;
    generate
        for (i = 0; i < cpq_pkg::CPQ_NUM_LEVELS; i++)
        begin : gLevel
            assign hit[i] = (tbl.subIndex == 32'(i));
        end
    endgenerate

    // One-hot select; no hit leaves an all-zero entry, which is the null type.
    always_comb
    begin
        tbl.entry = '0;
        tbl.present = |hit;
        for (int k = 0; k < cpq_pkg::CPQ_NUM_LEVELS; k++)
        begin
            if (hit[k])
            begin
                tbl.entry = cpq_pkg::CPQ_TABLE[k];
            end
        end
    end

endmodule

/* File: design/cpq_cache_parameter_query.sv */
// Cache parameter query responder: answers the cache description leaf per sub-index.
`timescale 1ns/1ns
// Summary of operation
// - Cache descriptions are returned only for a query with leaf selector 4.
// - Sub-index picks the cache level, numbered consecutively from zero.
// - Type field: 0 none, 1 data, 2 instruction, 3 unified; others reserved.
// - Bit 8 of word one set when the level needs no software initialisation.
// - Word one bits 25:14 give logical processors sharing the cache, minus one.
// - Word one bits 31:26 give cores in the package, minus one.
// - Word two bits 11:0 give coherency line size in bytes, minus one.
// - Word two bits 21:12 give physical line partitions, minus one.
// - Word two bits 31:22 give ways of associativity, minus one.
// - Word three gives the number of sets, minus one.
// - Leaves above 3 and below 80000000h hidden while legacy limit bit 22 set.
module cpq_cache_parameter_query (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic queryStrobe,
    input wire logic [31:0] queryLeaf,
    input wire logic [31:0] querySubIndex,
    input wire logic miscWrite,
    input wire logic [31:0] miscWriteData,
    output logic [31:0] cacheTypeAndSharingWord,
    output logic [31:0] cacheGeometryWord,
    output logic [31:0] cacheSetCountWord,
    output logic [31:0] cacheSpareWord,
    output logic resultValid,
    output logic leafServed,
    output logic [31:0] miscFeatureEnables
);

    cpq_table_if tblBus ();

    logic [31:0] miscFeatureEnables_reg;
    logic [31:0] wordA_next;
    logic [31:0] wordB_next;
    logic [31:0] wordC_next;
    logic [31:0] wordD_next;
    logic leafVisible;
    logic served_next;
    logic [31:0] wordA_reg;
    logic [31:0] wordB_reg;
    logic [31:0] wordC_reg;
    logic [31:0] wordD_reg;
    logic resultValid_reg;
    logic leafServed_reg;

    cpq_level_table levelTable (
        .tbl (tblBus.table_side)
    );

    // The sub-index goes straight to the table; the answer is captured one edge later.
    assign tblBus.subIndex = querySubIndex;

    // Software-written enables; reset leaves the legacy leaf limit clear so all leaves show.
    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            miscFeatureEnables_reg <= cpq_pkg::CPQ_MISC_RESET;
        end
        else if (miscWrite)
        begin
            miscFeatureEnables_reg <= miscWriteData;
        end
    end

    // A write in the same cycle as a query takes effect only for the next query.
    always_comb
    begin
        leafVisible = 1'b1;
        if ((queryLeaf > cpq_pkg::CPQ_LEAF_BASIC_LAST) && (queryLeaf < cpq_pkg::CPQ_LEAF_EXT_BASE)
            && miscFeatureEnables_reg[cpq_pkg::CPQ_LEGACY_LIMIT_BIT])
        begin
            leafVisible = 1'b0;
        end
        served_next = leafVisible && (queryLeaf == cpq_pkg::CPQ_LEAF_CACHE_PARAMS);
    end

    // Pack the result words; any unserved query or missing level reads all zero.
    always_comb
    begin
        wordA_next = '0;
        wordB_next = '0;
        wordC_next = '0;
        wordD_next = '0;
        if (served_next && tblBus.present)
        begin
            wordA_next[cpq_pkg::CPQ_A_TYPE_LSB +: cpq_pkg::CPQ_A_TYPE_W] = tblBus.entry.cacheType;
            wordA_next[cpq_pkg::CPQ_A_LEVEL_LSB +: cpq_pkg::CPQ_A_LEVEL_W] = tblBus.entry.level;
            wordA_next[cpq_pkg::CPQ_A_SELFINIT_BIT] = tblBus.entry.selfInit;
            wordA_next[cpq_pkg::CPQ_A_FULLASSOC_BIT] = tblBus.entry.fullyAssoc;
            wordA_next[cpq_pkg::CPQ_A_RSVD_LSB +: cpq_pkg::CPQ_A_RSVD_W] = '0;
            wordA_next[cpq_pkg::CPQ_A_SHARING_LSB +: cpq_pkg::CPQ_A_SHARING_W] = tblBus.entry.sharingMinus1;
            wordA_next[cpq_pkg::CPQ_A_CORES_LSB +: cpq_pkg::CPQ_A_CORES_W] = tblBus.entry.coresMinus1;
            wordB_next[cpq_pkg::CPQ_B_LINE_LSB +: cpq_pkg::CPQ_B_LINE_W] = tblBus.entry.lineMinus1;
            wordB_next[cpq_pkg::CPQ_B_PART_LSB +: cpq_pkg::CPQ_B_PART_W] = tblBus.entry.partMinus1;
            wordB_next[cpq_pkg::CPQ_B_WAYS_LSB +: cpq_pkg::CPQ_B_WAYS_W] = tblBus.entry.waysMinus1;
            wordC_next = tblBus.entry.setsMinus1;
        end
    end

    // Result words hold their value until the next query.
    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            wordA_reg <= '0;
            wordB_reg <= '0;
            wordC_reg <= '0;
            wordD_reg <= '0;
            leafServed_reg <= 1'b0;
        end
        else if (queryStrobe)
        begin
            wordA_reg <= wordA_next;
            wordB_reg <= wordB_next;
            wordC_reg <= wordC_next;
            wordD_reg <= wordD_next;
            leafServed_reg <= served_next;
        end
    end

    // One-cycle completion pulse for every query, served or not.
    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            resultValid_reg <= 1'b0;
        end
        else
        begin
            resultValid_reg <= queryStrobe;
        end
    end

    // Every output is a flip-flop.
    assign cacheTypeAndSharingWord = wordA_reg;
    assign cacheGeometryWord = wordB_reg;
    assign cacheSetCountWord = wordC_reg;
    assign cacheSpareWord = wordD_reg;
    assign resultValid = resultValid_reg;
    assign leafServed = leafServed_reg;
    assign miscFeatureEnables = miscFeatureEnables_reg;

endmodule

/* File: testbench/cpq_query_chk.sv */
// Port-level property checker for the cache parameter query responder.
`timescale 1ns/1ns
module cpq_query_chk (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic queryStrobe,
    input wire logic [31:0] queryLeaf,
    input wire logic [31:0] querySubIndex,
    input wire logic miscWrite,
    input wire logic [31:0] miscWriteData,
    input wire logic [31:0] cacheTypeAndSharingWord,
    input wire logic [31:0] cacheGeometryWord,
    input wire logic [31:0] cacheSetCountWord,
    input wire logic [31:0] cacheSpareWord,
    input wire logic resultValid,
    input wire logic leafServed,
    input wire logic [31:0] miscFeatureEnables
);
    // One clock domain, so clock and reset are given once for every property.
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_b);

    // The misc register is sampled before a same-edge write lands, so it is the value a query sees.
    chk_valid_pulse: assert property (queryStrobe |=> resultValid) else $error("no answer pulse");
    chk_no_pulse: assert property (!queryStrobe |=> !resultValid) else $error("stray answer pulse");
    chk_leaf_served: assert property (
        queryStrobe && queryLeaf == cpq_pkg::CPQ_LEAF_CACHE_PARAMS
        && !miscFeatureEnables[cpq_pkg::CPQ_LEGACY_LIMIT_BIT] |=> leafServed)
        else $error("leaf four not served");
    chk_other_leaf: assert property (
        queryStrobe && queryLeaf != cpq_pkg::CPQ_LEAF_CACHE_PARAMS |=> !leafServed && cacheSetCountWord == 32'h0)
        else $error("other leaf answered");
    chk_null_entry: assert property (
        queryStrobe && queryLeaf == cpq_pkg::CPQ_LEAF_CACHE_PARAMS && querySubIndex >= 32'h3
        && !miscFeatureEnables[cpq_pkg::CPQ_LEGACY_LIMIT_BIT] |=> leafServed && cacheTypeAndSharingWord == 32'h0)
        else $error("index past last level not null");
    chk_hidden_leaf: assert property (
        queryStrobe && queryLeaf > cpq_pkg::CPQ_LEAF_BASIC_LAST && queryLeaf < cpq_pkg::CPQ_LEAF_EXT_BASE
        && miscFeatureEnables[cpq_pkg::CPQ_LEGACY_LIMIT_BIT] |=> !leafServed && cacheGeometryWord == 32'h0)
        else $error("hidden leaf answered");
    chk_type_legal: assert property (resultValid |-> cacheTypeAndSharingWord[4:0] < 5'h4)
        else $error("reserved cache type");
    // A real cache level always carries a level number counted from one.
    chk_level_nonzero: assert property (
        resultValid && cacheTypeAndSharingWord[4:0] != 5'h00 |-> cacheTypeAndSharingWord[7:5] != 3'h0)
        else $error("cache level reads zero");
    chk_rsvd_zero: assert property (cacheSpareWord == 32'h0 && cacheTypeAndSharingWord[13:10] == 4'h0)
        else $error("reserved bits set");
    chk_words_hold: assert property (
        !queryStrobe |=> $stable(cacheTypeAndSharingWord) && $stable(cacheGeometryWord)
        && $stable(cacheSetCountWord) && $stable(leafServed))
        else $error("words moved without query");
    chk_misc_load: assert property (miscWrite |=> miscFeatureEnables == $past(miscWriteData))
        else $error("misc enables not loaded");
endmodule

bind cpq_cache_parameter_query cpq_query_chk i_cpq_query_chk (.mclk, .rst_b, .queryStrobe, .queryLeaf,
    .querySubIndex, .miscWrite, .miscWriteData, .cacheTypeAndSharingWord, .cacheGeometryWord,
    .cacheSetCountWord, .cacheSpareWord, .resultValid, .leafServed, .miscFeatureEnables);

/* File: testbench/cpq_cache_parameter_query_bench.sv */
// Self-checking bench for the cache parameter query responder.
`timescale 1ns/1ns
module cpq_cache_parameter_query_bench;
    logic mclk, rst_b, queryStrobe, miscWrite, resultValid, leafServed;
    logic [31:0] queryLeaf, querySubIndex, miscWriteData, cacheTypeAndSharingWord, cacheGeometryWord;
    logic [31:0] cacheSetCountWord, cacheSpareWord, miscFeatureEnables;
    logic [31:0] expA [3] = '{32'h0400_0121, 32'h0400_0122, 32'h0400_4143};
    logic [31:0] expC [3] = '{32'h0000_003f, 32'h0000_003f, 32'h0000_0fff};
    int num_errors = 0;
    int check_count = 0;
    int cycles = 0;

    cpq_cache_parameter_query i_cpq_cache_parameter_query (.mclk, .rst_b, .queryStrobe, .queryLeaf,
        .querySubIndex, .miscWrite, .miscWriteData, .cacheTypeAndSharingWord, .cacheGeometryWord,
        .cacheSetCountWord, .cacheSpareWord, .resultValid, .leafServed, .miscFeatureEnables);

    // Free-running 50 MHz clock.
    initial
    begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    // The sequence needs about forty cycles, so a ceiling of 500 only trips on a hang.
    always @(posedge mclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 500)
        begin
            num_errors++;
            test_done();
        end
    end

    task automatic test_done();
        $display("checks %0d, mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    // Called at a falling edge; the query is taken at the next rising edge and read back one half cycle later.
    task automatic query(input logic [31:0] leaf, input logic [31:0] sub);
        queryStrobe = 1'b1;
        queryLeaf = leaf;
        querySubIndex = sub;
        @(negedge mclk);
        queryStrobe = 1'b0;
    endtask

    // Compares the answer, then lets one edge pass so that the next strobe rises only after a low cycle.
    task automatic words(input logic [31:0] e1, input logic [31:0] e2, input logic [31:0] e3, input logic srv);
        cmp(cacheTypeAndSharingWord, e1);
        cmp(cacheGeometryWord, e2);
        cmp(cacheSetCountWord, e3);
        cmp(cacheSpareWord, 32'h0);
        cmp({31'h0, leafServed}, {31'h0, srv});
        cmp({31'h0, resultValid}, 32'h1);
        @(negedge mclk);
    endtask

    // Main sequence; every step starts and ends on a falling edge.
    initial
    begin
        rst_b = 1'b0;
        queryStrobe = 1'b0;
        queryLeaf = 32'h0;
        querySubIndex = 32'h0;
        miscWrite = 1'b0;
        miscWriteData = 32'h0;
        repeat (20) @(negedge mclk);
        rst_b = 1'b1;
        cmp(miscFeatureEnables, 32'h0);
        cmp(cacheTypeAndSharingWord, 32'h0);
        for (int i = 0; i < 3; i++)
        begin
            query(32'h4, i);
            words(expA[i], 32'h01c0_003f, expC[i], 1'b1);
        end
        $display("test levels finished");
        query(32'h4, 32'h3);
        words(32'h0, 32'h0, 32'h0, 1'b1);
        query(32'h4, 32'hffff_ffff);
        words(32'h0, 32'h0, 32'h0, 1'b1);
        query(32'h3, 32'h0);
        words(32'h0, 32'h0, 32'h0, 1'b0);
        query(32'h8000_0000, 32'h0);
        words(32'h0, 32'h0, 32'h0, 1'b0);
        $display("test leaves finished");
        miscWrite = 1'b1;
        miscWriteData = 32'h0040_0000;
        query(32'h4, 32'h0);
        miscWrite = 1'b0;
        words(expA[0], 32'h01c0_003f, expC[0], 1'b1);
        cmp(miscFeatureEnables, 32'h0040_0000);
        miscWrite = 1'b1;
        miscWriteData = 32'h0;
        query(32'h4, 32'h2);
        miscWrite = 1'b0;
        words(32'h0, 32'h0, 32'h0, 1'b0);
        $display("test leaf limit finished");
        queryStrobe = 1'b1;
        queryLeaf = 32'h4;
        querySubIndex = 32'h1;
        @(negedge mclk);
        cmp(cacheTypeAndSharingWord, expA[1]);
        cmp({31'h0, resultValid}, 32'h1);
        query(32'h4, 32'h2);
        words(expA[2], 32'h01c0_003f, expC[2], 1'b1);
        $display("test back to back finished");
        test_done();
    end
endmodule
